// ==== verilog/stpg_defs.svh ====
// named constants of the serial-link test-pattern generator
// assumes inclusion by bare name from the package and the design modules
`ifndef STPG_DEFS_SVH
`define STPG_DEFS_SVH

// geometry
`define STPG_LANES 8
`define STPG_GROUPS 4
`define STPG_SAMPLE_W 12
`define STPG_WORD_W 10
`define STPG_PRBS_W 23
`define STPG_ADDR_W 12
`define STPG_DATA_W 32
`define STPG_IDX_W 10
`define STPG_ADDR_LSB 2

// register indices, byte address is four times the index
`define STPG_IDX_CFG 10'h200
`define STPG_IDX_STAT 10'h201
`define STPG_IDX_TEST 10'h202

// configuration register fields
`define STPG_CFG_PAT 0
`define STPG_CFG_BG 1
`define STPG_CFG_CONT 2
`define STPG_CFG_LINK 3
`define STPG_CFG_DEC_LO 4
`define STPG_CFG_DEC_HI 6
`define STPG_CFG_DDR 7
`define STPG_TSEL_HI 3

// status register fields
`define STPG_ST_BANK_LO 0
`define STPG_ST_BANK_HI 2
`define STPG_ST_PWR_LO 3
`define STPG_ST_PWR_HI 10
`define STPG_ST_BYP 11
`define STPG_ST_PAT 12

// test-select codes
`define STPG_TSEL_NONE 4'h0
`define STPG_TSEL_P7 4'h1
`define STPG_TSEL_P15 4'h2
`define STPG_TSEL_P23 4'h3

// decimation codes
`define STPG_DEC_BYPASS 3'h0
`define STPG_DEC_4 3'h1
`define STPG_DEC_8 3'h2
`define STPG_DEC_10 3'h3

// lane power masks
`define STPG_PWR_8 8'hFF
`define STPG_PWR_4 8'h0F
`define STPG_PWR_2 8'h03
`define STPG_PWR_1 8'h01

// bank rotation
`define STPG_FG_OFFLINE 3'h1
`define STPG_LAST_BANK 3'h4
`define STPG_ROT_CYC 16'h0400

// per-bank pattern codes, lane n then lane n+4
`define STPG_B0_LO 12'h000
`define STPG_B0_HI 12'hFFF
`define STPG_B0_LO4 12'h040
`define STPG_B0_HI4 12'hFBF
`define STPG_B1_LO 12'h004
`define STPG_B1_HI 12'hFFE
`define STPG_B1_LO4 12'h080
`define STPG_B1_HI4 12'hF7F
`define STPG_B2_LO 12'h008
`define STPG_B2_HI 12'hFF7
`define STPG_B2_LO4 12'h100
`define STPG_B2_HI4 12'hEFF
`define STPG_B3_LO 12'h010
`define STPG_B3_HI 12'hFEF
`define STPG_B3_LO4 12'h200
`define STPG_B3_HI4 12'hDFF
`define STPG_B4_LO 12'h020
`define STPG_B4_HI 12'hFDF
`define STPG_B4_LO4 12'h400
`define STPG_B4_HI4 12'hBFF

// prbs taps, in bits back from the newest
`define STPG_P7_TA 6
`define STPG_P7_TB 7
`define STPG_P15_TA 14
`define STPG_P15_TB 15
`define STPG_P23_TA 18
`define STPG_P23_TB 23

`endif

// ==== verilog/stpg_pkg.sv ====
// types shared by the test-pattern generator modules
// assumes stpg_defs.svh is on the include path
package stpg_pkg;
  `include "stpg_defs.svh"
  typedef logic [`STPG_ADDR_W-1:0] stpg_addr_t;
  typedef logic [`STPG_DATA_W-1:0] stpg_data_t;
  typedef logic [`STPG_LANES*`STPG_SAMPLE_W-1:0] stpg_samples_t;
  typedef logic [`STPG_LANES*`STPG_WORD_W-1:0] stpg_words_t;
  typedef enum logic [1:0] {PRBS_NONE = 2'b00, PRBS_7 = 2'b01, PRBS_15 = 2'b11,
    PRBS_23 = 2'b10} stpg_prbs_e;
  typedef enum logic [1:0] {ST_NORMAL = 2'b00, ST_SEED = 2'b01, ST_PRBS = 2'b11} stpg_state_e;
endpackage

// ==== verilog/stpg_lane_if.sv ====
// per-lane bundle between the controller and the lane generators
// assumes stpg_pkg is compiled first
`timescale 1ns/10ps
`include "stpg_defs.svh"
interface stpg_lane_if;
  import stpg_pkg::*;
  stpg_prbs_e prbs_sel;
  logic seed_load;
  logic [`STPG_WORD_W-1:0] prbs_word;
  logic [2:0] bank;
  logic upper;
  logic phase;
  logic [`STPG_SAMPLE_W-1:0] code;
  modport ctrl (output prbs_sel, seed_load, bank, upper, phase, input prbs_word, code);
  modport lane (input prbs_sel, seed_load, bank, upper, phase, output prbs_word, code);
endinterface

// ==== verilog/stpg_prbs_lane.sv ====
// one lane's prbs generator and converter-pattern code register
// assumes the controller drives seed_load for one cycle on mode entry
`timescale 1ns/10ps
`include "stpg_defs.svh"
module stpg_prbs_lane #(parameter int LANE = 0) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  stpg_lane_if.lane bus
);
  import stpg_pkg::*;
  // lane number plus one: non-zero in the low seven bits, distinct per lane
  localparam logic [`STPG_PRBS_W-1:0] SEED = `STPG_PRBS_W'(LANE + 1);
  logic [`STPG_PRBS_W-1:0] state;
  logic [`STPG_PRBS_W-1:0] next_state;
  logic [`STPG_WORD_W-1:0] next_word;

  // feedback bit for the selected polynomial, state[0] is the newest bit
  function automatic logic fb(input logic [`STPG_PRBS_W-1:0] s, input stpg_prbs_e sel);
    unique case (sel)
      PRBS_7: fb = s[`STPG_P7_TA-1] ^ s[`STPG_P7_TB-1];
      PRBS_15: fb = s[`STPG_P15_TA-1] ^ s[`STPG_P15_TB-1];
      PRBS_23: fb = s[`STPG_P23_TA-1] ^ s[`STPG_P23_TB-1];
      PRBS_NONE: fb = 1'b0;
    endcase
  endfunction

  // ten bits per clock, bit 0 is sent first
  always_comb begin
    next_state = state;
    next_word = '0;
    for (int k = 0; k < `STPG_WORD_W; k++) begin
      next_word[k] = fb(next_state, bus.prbs_sel);
      next_state = {next_state[`STPG_PRBS_W-2:0], next_word[k]};
    end
  end

  // shift register, reseeded on every mode entry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= `STPG_PRBS_W'(1);
      bus.prbs_word <= '0;
    end else if (bus.seed_load) begin
      state <= SEED;
      bus.prbs_word <= '0;
    end else if (bus.prbs_sel != PRBS_NONE) begin
      state <= next_state;
      bus.prbs_word <= next_word;
    end
  end

  // bank code pair, lane n or lane n+4 flavour
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.code <= '0;
    end else begin
      unique case ({bus.upper, bus.bank})
        4'h0: bus.code <= bus.phase ? `STPG_B0_HI : `STPG_B0_LO;
        4'h1: bus.code <= bus.phase ? `STPG_B1_HI : `STPG_B1_LO;
        4'h2: bus.code <= bus.phase ? `STPG_B2_HI : `STPG_B2_LO;
        4'h3: bus.code <= bus.phase ? `STPG_B3_HI : `STPG_B3_LO;
        4'h4: bus.code <= bus.phase ? `STPG_B4_HI : `STPG_B4_LO;
        4'h8: bus.code <= bus.phase ? `STPG_B0_HI4 : `STPG_B0_LO4;
        4'h9: bus.code <= bus.phase ? `STPG_B1_HI4 : `STPG_B1_LO4;
        4'hA: bus.code <= bus.phase ? `STPG_B2_HI4 : `STPG_B2_LO4;
        4'hB: bus.code <= bus.phase ? `STPG_B3_HI4 : `STPG_B3_LO4;
        4'hC: bus.code <= bus.phase ? `STPG_B4_HI4 : `STPG_B4_LO4;
        default: bus.code <= '0;
      endcase
    end
  end
endmodule

// ==== verilog/stpg_bank_map.sv ====
// maps the four online converter banks onto lane groups
// assumes offline bank index in 0..4, from the controller's rotation
`timescale 1ns/10ps
module stpg_bank_map #(parameter int GROUP = 0) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] offline_i,
  output logic [2:0] bank_o
);
  import stpg_pkg::*;
  localparam logic [2:0] G = 3'(GROUP);

  // groups below the offline bank keep their index, the rest skip it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_o <= '0;
    end else begin
      bank_o <= (G < offline_i) ? G : 3'(G + 3'd1);
    end
  end
endmodule

// ==== verilog/stpg_top.sv ====
// serial-link test-pattern generator: apb registers, mode control,
// converter-level pattern, prbs lanes and lane power
// assumes an apb master on SYS_CLK_I and synchronous sample inputs
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "stpg_defs.svh"
module stpg_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire stpg_pkg::stpg_addr_t PADDR_I,
  input wire stpg_pkg::stpg_data_t PWDATA_I,
  output stpg_pkg::stpg_data_t PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire stpg_pkg::stpg_samples_t SAMPLE_I,
  output stpg_pkg::stpg_samples_t TX_SAMPLE_O,
  output logic TX_SAMPLE_VALID_O,
  output stpg_pkg::stpg_words_t TX_WORD_O,
  output logic TX_ENC_BYPASS_O,
  output logic [`STPG_LANES-1:0] LANE_PWR_O
);
  import stpg_pkg::*;

  // configuration fields
  logic pattern_en;
  logic background_cal_enable;
  logic continuous_cal_enable;
  logic link_en;
  logic [2:0] decim;
  logic ddr;
  logic [`STPG_TSEL_HI:0] serializer_test_select;

  // bus decode
  logic access;
  logic done;
  logic [`STPG_IDX_W-1:0] idx;
  logic aligned;
  logic hit;
  logic wr;
  stpg_data_t rd_value;

  // mode control and pattern state
  stpg_state_e fsm;
  stpg_state_e next_fsm;
  stpg_prbs_e req_sel;
  stpg_prbs_e active_sel;
  logic run_d;
  logic phase;
  logic pat_d;
  logic bypass;
  logic bg_run;
  logic [2:0] offline;
  logic [15:0] rot_cnt;
  logic [`STPG_LANES-1:0] next_pwr;
  logic [2:0] group_bank [`STPG_GROUPS];
  stpg_samples_t codes;
  stpg_words_t words;

  stpg_lane_if lane_bus[`STPG_LANES] ();

  // apb decode, one wait state per access
  assign access = PSEL_I && PENABLE_I;
  assign done = access && PREADY_O;
  assign idx = PADDR_I[`STPG_ADDR_W-1:`STPG_ADDR_LSB];
  assign aligned = (PADDR_I[`STPG_ADDR_LSB-1:0] == '0);
  assign hit = aligned && (idx == `STPG_IDX_CFG || idx == `STPG_IDX_STAT ||
    idx == `STPG_IDX_TEST);
  assign wr = done && PWRITE_I && !PSLVERR_O;

  // read mux, reserved bits read zero
  always_comb begin
    rd_value = '0;
    if (idx == `STPG_IDX_CFG) begin
      rd_value[`STPG_CFG_PAT] = pattern_en;
      rd_value[`STPG_CFG_BG] = background_cal_enable;
      rd_value[`STPG_CFG_CONT] = continuous_cal_enable;
      rd_value[`STPG_CFG_LINK] = link_en;
      rd_value[`STPG_CFG_DEC_HI:`STPG_CFG_DEC_LO] = decim;
      rd_value[`STPG_CFG_DDR] = ddr;
    end else if (idx == `STPG_IDX_STAT) begin
      rd_value[`STPG_ST_BANK_HI:`STPG_ST_BANK_LO] = offline;
      rd_value[`STPG_ST_PWR_HI:`STPG_ST_PWR_LO] = LANE_PWR_O;
      rd_value[`STPG_ST_BYP] = TX_ENC_BYPASS_O;
      rd_value[`STPG_ST_PAT] = pat_d;
    end else if (idx == `STPG_IDX_TEST) begin
      rd_value[`STPG_TSEL_HI:0] = serializer_test_select;
    end
  end

  // ready, read data and error, all prepared in the first access cycle
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= '0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= access && !PREADY_O;
      if (access && !PREADY_O) begin
        PRDATA_O <= (hit && !PWRITE_I) ? rd_value : '0;
        PSLVERR_O <= !hit || (PWRITE_I && idx == `STPG_IDX_STAT);
      end
    end
  end

  // writable registers, taken at the edge that completes the access
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pattern_en <= 1'b0;
      background_cal_enable <= 1'b0;
      continuous_cal_enable <= 1'b0;
      link_en <= 1'b0;
      decim <= `STPG_DEC_BYPASS;
      ddr <= 1'b0;
      serializer_test_select <= `STPG_TSEL_NONE;
    end else if (wr && idx == `STPG_IDX_CFG) begin
      pattern_en <= PWDATA_I[`STPG_CFG_PAT];
      background_cal_enable <= PWDATA_I[`STPG_CFG_BG];
      continuous_cal_enable <= PWDATA_I[`STPG_CFG_CONT];
      link_en <= PWDATA_I[`STPG_CFG_LINK];
      decim <= PWDATA_I[`STPG_CFG_DEC_HI:`STPG_CFG_DEC_LO];
      ddr <= PWDATA_I[`STPG_CFG_DDR];
    end else if (wr && idx == `STPG_IDX_TEST) begin
      serializer_test_select <= PWDATA_I[`STPG_TSEL_HI:0];
    end
  end

  // test-select decode; unknown codes leave the normal path running
  always_comb begin
    unique case (serializer_test_select)
      `STPG_TSEL_P7: req_sel = PRBS_7;
      `STPG_TSEL_P15: req_sel = PRBS_15;
      `STPG_TSEL_P23: req_sel = PRBS_23;
      default: req_sel = PRBS_NONE;
    endcase
  end

  // mode sequence: normal, seed for one cycle, then run
  always_comb begin
    next_fsm = fsm;
    unique case (fsm)
      ST_NORMAL: if (req_sel != PRBS_NONE) begin
        next_fsm = ST_SEED;
      end
      ST_SEED: next_fsm = ST_PRBS;
      ST_PRBS: if (req_sel != active_sel) begin
        next_fsm = ST_NORMAL;
      end
      default: next_fsm = ST_NORMAL;
    endcase
  end

  // mode register and the polynomial latched at seeding
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fsm <= ST_NORMAL;
      active_sel <= PRBS_NONE;
      run_d <= 1'b0;
    end else begin
      fsm <= next_fsm;
      run_d <= (fsm == ST_PRBS);
      if (fsm == ST_NORMAL && next_fsm == ST_SEED) begin
        active_sel <= req_sel;
      end
    end
  end

  // bank rotation while background calibration runs
  assign bg_run = background_cal_enable && continuous_cal_enable;
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      offline <= `STPG_FG_OFFLINE;
      rot_cnt <= '0;
    end else if (!bg_run) begin
      offline <= `STPG_FG_OFFLINE;
      rot_cnt <= '0;
    end else if (rot_cnt == `STPG_ROT_CYC - 16'd1) begin
      rot_cnt <= '0;
      offline <= (offline == `STPG_LAST_BANK) ? '0 : 3'(offline + 3'd1);
    end else begin
      rot_cnt <= 16'(rot_cnt + 16'd1);
    end
  end

  // pattern phase, low code first after enable
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      phase <= 1'b0;
      pat_d <= 1'b0;
    end else begin
      phase <= pattern_en && !phase;
      pat_d <= pattern_en;
    end
  end

  // lane groups share a bank: lane n and lane n+4
  for (genvar g = 0; g < `STPG_GROUPS; g++) begin : g_group
    stpg_bank_map #(.GROUP(g)) u_map (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .offline_i(offline),
      .bank_o(group_bank[g])
    );
  end

  // lane generators
  for (genvar l = 0; l < `STPG_LANES; l++) begin : g_lane
    assign lane_bus[l].prbs_sel = (fsm == ST_NORMAL) ? PRBS_NONE : active_sel;
    assign lane_bus[l].seed_load = (fsm == ST_SEED);
    assign lane_bus[l].bank = group_bank[l % `STPG_GROUPS];
    assign lane_bus[l].upper = (l >= `STPG_GROUPS);
    assign lane_bus[l].phase = phase;
    assign codes[l*`STPG_SAMPLE_W +: `STPG_SAMPLE_W] = lane_bus[l].code;
    assign words[l*`STPG_WORD_W +: `STPG_WORD_W] = lane_bus[l].prbs_word;
    stpg_prbs_lane #(.LANE(l)) u_lane (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .bus(lane_bus[l])
    );
  end

  // sample path: pattern replaces raw samples, bypass runs at full rate
  assign bypass = (decim == `STPG_DEC_BYPASS);
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TX_SAMPLE_O <= '0;
      TX_SAMPLE_VALID_O <= 1'b0;
    end else begin
      TX_SAMPLE_O <= pat_d ? codes : SAMPLE_I;
      TX_SAMPLE_VALID_O <= bypass || pat_d;
    end
  end

  // unencoded prbs words straight to the serializer
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TX_WORD_O <= '0;
      TX_ENC_BYPASS_O <= 1'b0;
    end else begin
      TX_WORD_O <= run_d ? words : '0;
      TX_ENC_BYPASS_O <= run_d;
    end
  end

  // lanes powered by decimation and rate only
  always_comb begin
    unique case (decim)
      `STPG_DEC_BYPASS: next_pwr = `STPG_PWR_8;
      `STPG_DEC_4: next_pwr = ddr ? `STPG_PWR_2 : `STPG_PWR_4;
      `STPG_DEC_8, `STPG_DEC_10: next_pwr = ddr ? `STPG_PWR_1 : `STPG_PWR_2;
      default: next_pwr = `STPG_PWR_1;
    endcase
  end

  // lane power register
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LANE_PWR_O <= `STPG_PWR_8;
    end else begin
      LANE_PWR_O <= next_pwr;
    end
  end

  // checks on the generated streams, bank rotation, test select and lane power
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  property p_pat_repeat;
    pat_d && $past(pat_d) && $past(pat_d, 2) && !bg_run && $past(!bg_run, 3)
      |=> TX_SAMPLE_O == $past(TX_SAMPLE_O, 2);
  endproperty
  a_pat_repeat: assert property (p_pat_repeat) else $error("pattern not two-frame periodic");

  property p_pat_lane0;
    $rose(pat_d) && !bg_run |=> TX_SAMPLE_O[`STPG_SAMPLE_W-1:0] == `STPG_B0_LO
      ##1 TX_SAMPLE_O[`STPG_SAMPLE_W-1:0] == `STPG_B0_HI;
  endproperty
  a_pat_lane0: assert property (p_pat_lane0) else $error("lane 0 pattern wrong");

  property p_pat_lane7;
    $rose(pat_d) && !bg_run |=> TX_SAMPLE_O[`STPG_LANES*`STPG_SAMPLE_W-1 -: `STPG_SAMPLE_W]
      == `STPG_B4_LO4;
  endproperty
  a_pat_lane7: assert property (p_pat_lane7) else $error("lane 7 low code wrong");

  property p_bank_hold;
    bg_run && rot_cnt != `STPG_ROT_CYC - 16'd1 |=> $stable(offline);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved early");

  property p_fg_bank;
    !bg_run |=> offline == `STPG_FG_OFFLINE;
  endproperty
  a_fg_bank: assert property (p_fg_bank) else $error("offline bank not fixed");

  property p_tsel_write;
    wr && idx == `STPG_IDX_TEST |=> serializer_test_select == $past(PWDATA_I[`STPG_TSEL_HI:0]);
  endproperty
  a_tsel_write: assert property (p_tsel_write) else $error("test select not stored");

  property p_pwr;
    decim == `STPG_DEC_BYPASS |=> LANE_PWR_O == `STPG_PWR_8;
  endproperty
  a_pwr: assert property (p_pwr) else $error("lane power wrong");

  property p_bypass;
    fsm == ST_PRBS |-> ##2 TX_ENC_BYPASS_O;
  endproperty
  a_bypass: assert property (p_bypass) else $error("encoder not bypassed");

  property p_prbs7;
    TX_ENC_BYPASS_O && active_sel == PRBS_7 |-> TX_WORD_O[7] == (TX_WORD_O[1] ^ TX_WORD_O[0])
      && TX_WORD_O[`STPG_WORD_W-1:0] != '0;
  endproperty
  a_prbs7: assert property (p_prbs7) else $error("prbs7 recurrence broken");

  property p_prbs15;
    TX_ENC_BYPASS_O && $past(TX_ENC_BYPASS_O) && $past(TX_ENC_BYPASS_O, 2)
      && active_sel == PRBS_15 |-> TX_WORD_O[4] == ($past(TX_WORD_O[0]) ^ $past(TX_WORD_O[9], 2));
  endproperty
  a_prbs15: assert property (p_prbs15) else $error("prbs15 recurrence broken");

  property p_phase;
    TX_ENC_BYPASS_O && active_sel == PRBS_7 |->
      TX_WORD_O[`STPG_WORD_W-1:0] != TX_WORD_O[2*`STPG_WORD_W-1:`STPG_WORD_W];
  endproperty
  a_phase: assert property (p_phase) else $error("lanes share a prbs phase");

  c_prbs7: cover property (fsm == ST_SEED ##1 fsm == ST_PRBS && active_sel == PRBS_7);
  c_prbs23: cover property (TX_ENC_BYPASS_O && active_sel == PRBS_23);
  c_rotate: cover property (bg_run && $changed(offline));
  c_pattern: cover property (pat_d [*4]);
endmodule

// ==== bench/stpg_rx_model.sv ====
// far-end receiver: self-locks on each lane's prbs bits, counts bit errors
// assumes words are settled at the falling clock edge
`timescale 1ns/10ps
module stpg_rx_model (
  input wire logic clk_i,
  input wire logic bypass_i,
  input wire stpg_pkg::stpg_words_t word_i,
  input wire logic [4:0] tap_a_i,
  input wire logic [4:0] tap_b_i,
  output int bits_o,
  output int errs_o,
  output int ones_o
);
  import stpg_pkg::*;
  logic [31:0] hist [8];
  logic nb;
  // no seed assumed: the history fills first, then each bit is checked
  always @(negedge clk_i) begin
    if (bypass_i !== 1'b1) begin
      bits_o = 0;
      errs_o = 0;
      ones_o = 0;
    end else begin
      for (int l = 0; l < 8; l++) begin
        for (int k = 0; k < 10; k++) begin
          nb = word_i[10*l+k];  // raw bits, bit0 first
          if (bits_o >= 23 && nb !== (hist[l][tap_a_i-1] ^ hist[l][tap_b_i-1])) begin
            errs_o++;
          end
          ones_o += nb;
          hist[l] = {hist[l][30:0], nb};
        end
      end
      bits_o += 10;
    end
  end
endmodule

// ==== bench/serial_link_test_pattern_gen_test.sv ====
// self-checking bench of the serial-link test-pattern generator
// assumes the design files and stpg_rx_model are compiled first
`timescale 1ns/10ps
`include "stpg_defs.svh"
module serial_link_test_pattern_gen_test;
  import stpg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  stpg_addr_t paddr = '0;
  stpg_data_t pwdata = '0;
  stpg_samples_t samp = 96'h1234_5678_9ABC_DEF0_1357_9BDF;
  stpg_data_t prdata;
  logic pready, pslverr, tx_valid, enc_byp;
  stpg_samples_t tx_samp;
  stpg_words_t tx_word;
  logic [7:0] pwr_o;
  logic [4:0] tap_a = 5'h6;
  logic [4:0] tap_b = 5'h7;
  int rx_bits, rx_errs, rx_ones;
  int bad_count = 0;
  int total_checks = 0;
  // bank codes: low, high, low on upper lane, high on upper lane
  logic [11:0] codes [20] = '{`STPG_B0_LO, `STPG_B0_HI, `STPG_B0_LO4, `STPG_B0_HI4,
    `STPG_B1_LO, `STPG_B1_HI, `STPG_B1_LO4, `STPG_B1_HI4, `STPG_B2_LO, `STPG_B2_HI,
    `STPG_B2_LO4, `STPG_B2_HI4, `STPG_B3_LO, `STPG_B3_HI, `STPG_B3_LO4, `STPG_B3_HI4,
    `STPG_B4_LO, `STPG_B4_HI, `STPG_B4_LO4, `STPG_B4_HI4};

  stpg_top u_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SAMPLE_I(samp), .TX_SAMPLE_O(tx_samp),
    .TX_SAMPLE_VALID_O(tx_valid), .TX_WORD_O(tx_word), .TX_ENC_BYPASS_O(enc_byp),
    .LANE_PWR_O(pwr_o));
  stpg_rx_model u_rx (.clk_i(clk), .bypass_i(enc_byp), .word_i(tx_word), .tap_a_i(tap_a),
    .tap_b_i(tap_b), .bits_o(rx_bits), .errs_o(rx_errs), .ones_o(rx_ones));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, started and ended at a rising edge
  task automatic apb(input logic wr, input stpg_addr_t a, input stpg_data_t d,
      output logic [32:0] r);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // ready sampled at a rising edge, answer taken at that same edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge, so a following setup never reassigns psel in this step
    @(posedge clk);
  endtask

  // transfer and compare error flag and, on reads, data
  task automatic acc(input logic wr, input stpg_addr_t a, input stpg_data_t d,
      input logic [32:0] x);
    logic [32:0] r;
    apb(wr, a, d, r);
    if (wr) r[31:0] = x[31:0];
    chk(r, x);
  endtask

  function automatic stpg_samples_t exp_pat(input int off, input logic hi);
    int bk;
    for (int l = 0; l < 8; l++) begin
      bk = (l % 4 < off) ? l % 4 : l % 4 + 1;
      exp_pat[12*l +: 12] = codes[4*bk + 2*(l/4) + hi];
    end
  endfunction

  task automatic test_regs();
    @(negedge clk);
    chk({tx_valid, tx_samp}, {1'b1, samp});
    @(posedge clk);
    acc(0, 12'h800, 0, 33'h0);
    acc(0, 12'h804, 0, 33'h0_0000_07F9);
    acc(0, 12'h000, 0, 33'h1_0000_0000);
    acc(0, 12'h801, 0, 33'h1_0000_0000);
    acc(1, 12'h804, 32'h0000_FFFF, 33'h1_0000_0000);
    acc(1, 12'h808, 32'h0000_00F5, 33'h0);
    acc(0, 12'h808, 0, 33'h0_0000_0005);
    repeat (6) @(negedge clk);
    chk({enc_byp, tx_word}, 0);
    @(posedge clk);
    acc(1, 12'h808, 0, 33'h0);
  endtask

  task automatic test_pattern();
    acc(1, 12'h800, 32'h0000_0001, 33'h0);
    @(posedge clk);
    @(negedge clk);
    chk({tx_valid, tx_samp}, {1'b1, exp_pat(1, 0)});
    @(negedge clk);
    chk(tx_samp, exp_pat(1, 1));
    @(negedge clk);
    chk(tx_samp, exp_pat(1, 0));
    @(posedge clk);
  endtask

  task automatic test_bg();
    logic [32:0] r1, r2;
    stpg_samples_t v;
    int prev;
    acc(1, 12'h800, 32'h0000_0007, 33'h0);
    prev = -1;
    for (int i = 0; i < 6; i++) begin
      apb(0, 12'h804, 0, r1);
      repeat (4) @(posedge clk);
      @(negedge clk);
      v = tx_samp;
      @(posedge clk);
      apb(0, 12'h804, 0, r2);
      if (r1 === r2) begin
        chk(v, exp_pat(r1[2:0], v[11]));
        if (prev >= 0) chk(r1[2:0], (prev + 1) % 5);
        prev = r1[2:0];
      end else begin
        prev = -1;
      end
      repeat (1020) @(posedge clk);
    end
    acc(1, 12'h800, 0, 33'h0);
  endtask

  // link stays disabled while the select changes
  task automatic test_prbs(input logic [3:0] sel, input logic [4:0] a, input logic [4:0] b);
    int n;
    tap_a <= a;
    tap_b <= b;
    acc(1, 12'h808, {28'h0, sel}, 33'h0);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (enc_byp !== 1'b1 && n < 20);
    chk(n, 4);
    repeat (300) @(negedge clk);
    chk(rx_errs, 0);
    chk(rx_bits > 2000 && rx_ones > 100, 1);
    for (int i = 0; i < 7; i++) begin
      if (sel == 4'h1) chk(tx_word[10*i +: 10] == tx_word[10*i+10 +: 10], 0);
    end
    chk(pwr_o, 8'hFF);
    @(posedge clk);
    acc(1, 12'h808, 0, 33'h0);
    repeat (8) @(negedge clk);
    chk({enc_byp, tx_word}, 0);
    @(posedge clk);
  endtask

  task automatic test_power();
    logic [7:0] cfg [7] = '{8'h00, 8'h10, 8'h90, 8'h20, 8'hA0, 8'h30, 8'h40};
    logic [7:0] msk [7] = '{8'hFF, 8'h0F, 8'h03, 8'h03, 8'h01, 8'h03, 8'h01};
    acc(1, 12'h808, 32'h0000_0001, 33'h0);
    for (int i = 0; i < 7; i++) begin
      acc(1, 12'h800, {24'h0, cfg[i]}, 33'h0);
      repeat (4) @(negedge clk);
      chk(pwr_o, msk[i]);
      chk(tx_valid, i == 0);
      @(posedge clk);
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk);
    chk({pwr_o, tx_word}, {8'hFF, 80'h0});
    rst_b <= 1'b1;
    @(posedge clk);
    test_regs();
    test_pattern();
    test_bg();
    test_prbs(4'h1, 5'h6, 5'h7);
    test_prbs(4'h2, 5'hE, 5'hF);
    test_prbs(4'h3, 5'h12, 5'h17);
    test_power();
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
